// ==== design/afd_pkg.sv ====
// Constants shared by the audio FIFO, DMA request and event flag logic.
package afd_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int FIFO_DEPTH = 8;
	localparam int PTR_W = 3;
	localparam int LVL_W = 8;
	localparam int THD_W = 7;
	localparam int FLAG_W = 4;

	localparam logic [ADDR_W-1:0] OFS_DMA_CTRL = 12'h030;
	localparam logic [ADDR_W-1:0] OFS_FIFO_DATA = 12'h040;
	localparam logic [ADDR_W-1:0] OFS_EVENT_FLAGS = 12'h050;
	localparam logic [ADDR_W-1:0] OFS_EVENT_EN = 12'h054;

	localparam int RX_LVL_LSB = 24;
	localparam int TX_LVL_LSB = 16;
	localparam int RX_EN_BIT = 15;
	localparam int RX_THD_LSB = 8;
	localparam int TX_EN_BIT = 7;
	localparam int TX_THD_LSB = 0;

	localparam int FLAG_TX_HALF = 3;
	localparam int FLAG_TX_ONE = 2;
	localparam int FLAG_RX_THD = 1;
	localparam int FLAG_RX_OVR = 0;

	localparam logic [LVL_W-1:0] LVL_HALF = 8'h04;
	localparam logic [LVL_W-1:0] LVL_ONE = 8'h01;
	localparam logic [LVL_W-1:0] LVL_FULL = 8'h08;

	localparam logic [THD_W-1:0] RST_THD = 7'h00;
	localparam logic RST_CH_EN = 1'b0;
	localparam logic [FLAG_W-1:0] RST_FLAGS = 4'h0;
	localparam logic [DATA_W-1:0] RST_DATA = 32'h0000_0000;
endpackage : afd_pkg

// ==== design/afd_fifo_if.sv ====
// Push/pop port of one word FIFO.
`timescale 1ns/1ns
interface afd_fifo_if;
	logic push;
	logic [afd_pkg::DATA_W-1:0] push_data;
	logic pop;
	logic [afd_pkg::DATA_W-1:0] pop_data;
	logic [afd_pkg::LVL_W-1:0] level;
	logic full;
	logic empty;
	modport owner (input push, input push_data, input pop,
		output pop_data, output level, output full, output empty);
	modport user (output push, output push_data, output pop,
		input pop_data, input level, input full, input empty);
endinterface : afd_fifo_if

// ==== design/afd_fifo.sv ====
// Word FIFO in flip-flops with a fill level.
`timescale 1ns/1ns
module afd_fifo (
	input wire logic clk,
	input wire logic resetn,
	afd_fifo_if.owner f
);
	typedef struct packed {
		logic [afd_pkg::FIFO_DEPTH-1:0][afd_pkg::DATA_W-1:0] mem;
		logic [afd_pkg::PTR_W-1:0] wr_ptr;
		logic [afd_pkg::PTR_W-1:0] rd_ptr;
		logic [afd_pkg::LVL_W-1:0] level;
	} afd_fifo_state_t;

	afd_fifo_state_t s;
	afd_fifo_state_t next_s;
	logic do_push;
	logic do_pop;

	// A push into a full FIFO is refused even if a pop happens in the same cycle.
	assign do_push = f.push && (s.level != afd_pkg::LVL_FULL);
	assign do_pop = f.pop && (s.level != '0);

	always_comb begin
		next_s = s;
		if (do_push) begin
			next_s.mem[s.wr_ptr] = f.push_data;
			next_s.wr_ptr = s.wr_ptr + 1'b1;
		end
		if (do_pop) begin
			next_s.rd_ptr = s.rd_ptr + 1'b1;
		end
		case ({do_push, do_pop})
			2'b10: next_s.level = s.level + 1'b1;
			2'b01: next_s.level = s.level - 1'b1;
			default: next_s.level = s.level;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign f.pop_data = s.mem[s.rd_ptr];
	assign f.level = s.level;
	assign f.full = (s.level == afd_pkg::LVL_FULL);
	assign f.empty = (s.level == '0);
endmodule : afd_fifo

// ==== design/afd_event_flags.sv ====
// Sticky write-one-to-clear event flags with an enable mask and interrupt.
`timescale 1ns/1ns
module afd_event_flags (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [afd_pkg::FLAG_W-1:0] set,
	input wire logic flag_wr,
	input wire logic en_wr,
	input wire logic [afd_pkg::FLAG_W-1:0] wdata,
	output logic [afd_pkg::FLAG_W-1:0] flags,
	output logic [afd_pkg::FLAG_W-1:0] enables,
	output logic irq
);
	typedef struct packed {
		logic [afd_pkg::FLAG_W-1:0] flags;
		logic [afd_pkg::FLAG_W-1:0] enables;
	} afd_flag_state_t;

	afd_flag_state_t s;
	afd_flag_state_t next_s;

	always_comb begin
		next_s = s;
		// A set arriving with its clear keeps the flag high.
		if (flag_wr) begin
			next_s.flags = s.flags & ~wdata;
		end
		next_s.flags = next_s.flags | set;
		if (en_wr) begin
			next_s.enables = wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			s.flags <= afd_pkg::RST_FLAGS;
			s.enables <= afd_pkg::RST_FLAGS;
		end else begin
			s <= next_s;
		end
	end

	assign flags = s.flags;
	assign enables = s.enables;
	assign irq = |(s.flags & s.enables);
endmodule : afd_event_flags

// ==== design/afd_audio_fifo.sv ====
// APB register block with transmit/receive FIFOs, DMA requests and event flags.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ns
module afd_audio_fifo (
	input wire logic clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [afd_pkg::ADDR_W-1:0] paddr,
	input wire logic [afd_pkg::DATA_W-1:0] pwdata,
	output logic [afd_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	output logic dma_rx_req,
	output logic dma_tx_req,
	input wire logic rx_word_valid,
	input wire logic [afd_pkg::DATA_W-1:0] rx_word_data,
	output logic tx_word_valid,
	output logic [afd_pkg::DATA_W-1:0] tx_word_data,
	input wire logic tx_word_take
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic rx_en;
		logic [afd_pkg::THD_W-1:0] rx_thd;
		logic tx_en;
		logic [afd_pkg::THD_W-1:0] tx_thd;
		logic [afd_pkg::DATA_W-1:0] rdata;
		logic [afd_pkg::LVL_W-1:0] tx_lvl_prev;
		logic rx_above_prev;
	} afd_main_state_t;

	afd_main_state_t s;
	afd_main_state_t next_s;

	// Address match against one register offset.
	function automatic logic afd_hit(
		input logic [afd_pkg::ADDR_W-1:0] addr,
		input logic [afd_pkg::ADDR_W-1:0] ofs
	);
		afd_hit = (addr == ofs);
	endfunction : afd_hit

	// ----------------------------------------------------------------
	// FIFOs
	// ----------------------------------------------------------------
	afd_fifo_if tx_f ();
	afd_fifo_if rx_f ();

	afd_fifo u_tx_fifo (
		.clk (clk),
		.resetn (resetn),
		.f (tx_f.owner)
	);

	afd_fifo u_rx_fifo (
		.clk (clk),
		.resetn (resetn),
		.f (rx_f.owner)
	);

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	logic setup;
	logic access;
	logic sel_dma;
	logic sel_fifo;
	logic sel_flags;
	logic sel_en;
	logic mapped;
	logic wr_access;
	logic rx_above;
	logic [afd_pkg::FLAG_W-1:0] flag_set;
	logic [afd_pkg::FLAG_W-1:0] flags;
	logic [afd_pkg::FLAG_W-1:0] enables;

	assign setup = psel && !penable;
	assign access = psel && penable;
	assign sel_dma = afd_hit(paddr, afd_pkg::OFS_DMA_CTRL);
	assign sel_fifo = afd_hit(paddr, afd_pkg::OFS_FIFO_DATA);
	assign sel_flags = afd_hit(paddr, afd_pkg::OFS_EVENT_FLAGS);
	assign sel_en = afd_hit(paddr, afd_pkg::OFS_EVENT_EN);
	assign mapped = sel_dma || sel_fifo || sel_flags || sel_en;
	assign wr_access = access && pwrite && mapped;

	// Zero wait states: every access phase completes at once.
	assign pready = access;
	assign pslverr = access && !mapped;
	assign prdata = s.rdata;

	// ----------------------------------------------------------------
	// FIFO ports
	// ----------------------------------------------------------------
	assign tx_f.push = wr_access && sel_fifo;
	assign tx_f.push_data = pwdata;
	assign tx_f.pop = tx_word_take;
	assign tx_word_valid = !tx_f.empty;
	assign tx_word_data = tx_f.pop_data;

	assign rx_f.push = rx_word_valid;
	assign rx_f.push_data = rx_word_data;
	assign rx_f.pop = access && !pwrite && sel_fifo;

	// ----------------------------------------------------------------
	// DMA requests
	// ----------------------------------------------------------------
	assign rx_above = (rx_f.level > {1'b0, s.rx_thd});
	assign dma_rx_req = s.rx_en && rx_above;
	assign dma_tx_req = s.tx_en && (tx_f.level < {1'b0, s.tx_thd});

	// ----------------------------------------------------------------
	// Events
	// ----------------------------------------------------------------
	always_comb begin
		flag_set = '0;
		flag_set[afd_pkg::FLAG_TX_HALF] = (s.tx_lvl_prev > afd_pkg::LVL_HALF)
			&& (tx_f.level <= afd_pkg::LVL_HALF);
		flag_set[afd_pkg::FLAG_TX_ONE] = (s.tx_lvl_prev > afd_pkg::LVL_ONE)
			&& (tx_f.level == afd_pkg::LVL_ONE);
		flag_set[afd_pkg::FLAG_RX_THD] = rx_above && !s.rx_above_prev;
		// The incoming word is dropped by the full FIFO itself.
		flag_set[afd_pkg::FLAG_RX_OVR] = rx_word_valid && rx_f.full;
	end

	afd_event_flags u_flags (
		.clk (clk),
		.resetn (resetn),
		.set (flag_set),
		.flag_wr (wr_access && sel_flags),
		.en_wr (wr_access && sel_en),
		.wdata (pwdata[afd_pkg::FLAG_W-1:0]),
		.flags (flags),
		.enables (enables),
		.irq (irq)
	);

	// ----------------------------------------------------------------
	// Registers and read data
	// ----------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.tx_lvl_prev = tx_f.level;
		next_s.rx_above_prev = rx_above;
		if (wr_access && sel_dma) begin
			next_s.rx_en = pwdata[afd_pkg::RX_EN_BIT];
			next_s.rx_thd = pwdata[afd_pkg::RX_THD_LSB +: afd_pkg::THD_W];
			next_s.tx_en = pwdata[afd_pkg::TX_EN_BIT];
			next_s.tx_thd = pwdata[afd_pkg::TX_THD_LSB +: afd_pkg::THD_W];
		end
		// Read data is captured in the setup phase so it is stable for the access.
		if (setup && !pwrite) begin
			next_s.rdata = afd_pkg::RST_DATA;
			if (sel_dma) begin
				next_s.rdata[afd_pkg::RX_LVL_LSB +: afd_pkg::LVL_W] = rx_f.level;
				next_s.rdata[afd_pkg::TX_LVL_LSB +: afd_pkg::LVL_W] = tx_f.level;
				next_s.rdata[afd_pkg::RX_EN_BIT] = s.rx_en;
				next_s.rdata[afd_pkg::RX_THD_LSB +: afd_pkg::THD_W] = s.rx_thd;
				next_s.rdata[afd_pkg::TX_EN_BIT] = s.tx_en;
				next_s.rdata[afd_pkg::TX_THD_LSB +: afd_pkg::THD_W] = s.tx_thd;
			end else if (sel_fifo) begin
				if (!rx_f.empty) begin
					next_s.rdata = rx_f.pop_data;
				end
			end else if (sel_flags) begin
				next_s.rdata[afd_pkg::FLAG_W-1:0] = flags;
			end else if (sel_en) begin
				next_s.rdata[afd_pkg::FLAG_W-1:0] = enables;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			s.rx_en <= afd_pkg::RST_CH_EN;
			s.rx_thd <= afd_pkg::RST_THD;
			s.tx_en <= afd_pkg::RST_CH_EN;
			s.tx_thd <= afd_pkg::RST_THD;
			s.rdata <= afd_pkg::RST_DATA;
			s.tx_lvl_prev <= '0;
			s.rx_above_prev <= 1'b0;
		end else begin
			s <= next_s;
		end
	end
endmodule : afd_audio_fifo

// ==== testbench/afd_monitor.sv ====
// Port checker for the audio FIFO register block.
`timescale 1ns/1ns
module afd_monitor (
	input wire logic clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic irq,
	input wire logic dma_rx_req,
	input wire logic dma_tx_req,
	input wire logic rx_word_valid,
	input wire logic tx_word_valid,
	input wire logic tx_word_take
);
	logic [7:0] rc;
	logic [7:0] tc;
	logic [15:0] cs;
	logic [3:0] es;
	logic [31:0] cv;
	logic wa;
	logic ra;
	assign wa = psel && penable && pwrite;
	assign ra = psel && penable && !pwrite;
	assign cv = {rc, tc, cs};
	// Shadow levels and settings, rebuilt from port traffic alone.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			rc <= 8'h00;
			tc <= 8'h00;
			cs <= 16'h0000;
			es <= 4'h0;
		end else begin
			rc <= rc + {7'h00, rx_word_valid && rc < 8'h08}
				- {7'h00, ra && paddr == 12'h040 && rc != 8'h00};
			tc <= tc + {7'h00, wa && paddr == 12'h040 && tc < 8'h08}
				- {7'h00, tx_word_take && tc != 8'h00};
			if (wa && paddr == 12'h030) cs <= pwdata[15:0];
			if (wa && paddr == 12'h054) es <= pwdata[3:0];
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	property p_tx_valid; tx_word_valid == (tc != 8'h00); endproperty
	a_tx_valid: assert property (p_tx_valid) else $error("tx level");
	property p_tx_req; dma_tx_req == (cs[7] && tc < {1'b0, cs[6:0]}); endproperty
	a_tx_req: assert property (p_tx_req) else $error("tx request");
	property p_rx_req; dma_rx_req == (cs[15] && rc > {1'b0, cs[14:8]}); endproperty
	a_rx_req: assert property (p_rx_req) else $error("rx request");
	property p_rx_off; !cs[15] |-> !dma_rx_req; endproperty
	a_rx_off: assert property (p_rx_off) else $error("rx off");
	property p_tx_off; !cs[7] |-> !dma_tx_req; endproperty
	a_tx_off: assert property (p_tx_off) else $error("tx off");
	property p_ctrl_rd; ra && paddr == 12'h030 |-> prdata == $past(cv); endproperty
	a_ctrl_rd: assert property (p_ctrl_rd) else $error("ctrl read");
	property p_mask; es == 4'h0 |-> !irq; endproperty
	a_mask: assert property (p_mask) else $error("irq masked");
	property p_ovr; rx_word_valid && rc == 8'h08 && es[0] |=> irq || !es[0]; endproperty
	a_ovr: assert property (p_ovr) else $error("overrun");
endmodule : afd_monitor
bind afd_audio_fifo afd_monitor mon (.clk(clk), .resetn(resetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.irq(irq), .dma_rx_req(dma_rx_req), .dma_tx_req(dma_tx_req),
	.rx_word_valid(rx_word_valid), .tx_word_valid(tx_word_valid), .tx_word_take(tx_word_take));

// ==== testbench/afd_serial_model.sv ====
// Serial shifter stand-in: pushes received words, takes transmit words.
`timescale 1ns/1ns
module afd_serial_model (
	input wire logic clk,
	output logic rx_word_valid,
	output logic [31:0] rx_word_data,
	input wire logic [31:0] tx_word_data,
	output logic tx_word_take
);
	logic [31:0] seen[$];
	initial begin
		rx_word_valid = 1'b0;
		rx_word_data = 32'h0000_0000;
		tx_word_take = 1'b0;
	end
	// Data is inverted after the strobe so a stale word never looks valid.
	task automatic push(input logic [31:0] d);
		@(posedge clk);
		rx_word_valid <= 1'b1;
		rx_word_data <= d;
		@(posedge clk);
		rx_word_valid <= 1'b0;
		rx_word_data <= ~d;
	endtask : push
	task automatic take();
		@(posedge clk);
		tx_word_take <= 1'b1;
		@(posedge clk);
		seen.push_back(tx_word_data);
		tx_word_take <= 1'b0;
	endtask : take
endmodule : afd_serial_model

// ==== testbench/testbench.sv ====
// Self-checking bench for the audio FIFO register block.
`timescale 1ns/1ns
module testbench;
	logic clk, resetn, psel, penable, pwrite, pready, pslverr, irq, rxr, txr, e;
	logic rxv, txv, take;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, w, rxd, txd, q[$];
	int error_cnt = 0;
	int samples_checked = 0;
	int cyc = 0;
	afd_audio_fifo dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .dma_rx_req(rxr), .dma_tx_req(txr), .rx_word_valid(rxv),
		.rx_word_data(rxd), .tx_word_valid(txv), .tx_word_data(txd), .tx_word_take(take));
	afd_serial_model sm (.clk(clk), .rx_word_valid(rxv), .rx_word_data(rxd),
		.tx_word_data(txd), .tx_word_take(take));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic end_sim();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : end_sim
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			end_sim();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Expected control word: receive level, transmit level, then the settings half.
	function automatic logic [31:0] ctrl_word(input logic [7:0] rl, input logic [7:0] tl,
		input logic [15:0] c);
		ctrl_word = {rl, tl, c};
	endfunction : ctrl_word
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Only the bench timeout ends a wait for the answer.
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask : apb
	initial begin
		resetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		void'($urandom(45));
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		apb(0, 12'h030, 0);
		chk(rd, 32'h0);
		apb(0, 12'h050, 0);
		chk(rd, 32'h0);
		apb(1, 12'h030, 32'h0000_8283);
		apb(1, 12'h054, 32'h0000_000f);
		apb(0, 12'h054, 0);
		chk(rd, 32'hf);
		chk(32'(txr), 32'h1);
		chk(32'(rxr), 32'h0);
		for (int i = 0; i < 9; i++) begin
			w = $urandom;
			if (i < 8) q.push_back(w);
			apb(1, 12'h040, w);
		end
		apb(0, 12'h030, 0);
		chk(rd, ctrl_word(8'h00, 8'h08, 16'h8283));
		chk(32'(txr), 32'h0);
		chk(32'(irq), 32'h0);
		repeat (8) begin
			repeat ($urandom_range(3)) @(posedge clk);
			sm.take();
		end
		for (int i = 0; i < 8; i++) chk(sm.seen[i], q[i]);
		apb(0, 12'h050, 0);
		chk(rd, 32'hc);
		chk(32'(irq), 32'h1);
		chk(32'(txr), 32'h1);
		apb(1, 12'h050, 32'h4);
		apb(0, 12'h050, 0);
		chk(rd, 32'h8);
		apb(1, 12'h050, 32'h0);
		apb(0, 12'h050, 0);
		chk(rd, 32'h8);
		apb(1, 12'h050, 32'h8);
		chk(32'(irq), 32'h0);
		q.delete();
		for (int i = 0; i < 9; i++) begin
			w = $urandom;
			if (i < 8) q.push_back(w);
			sm.push(w);
		end
		apb(0, 12'h030, 0);
		chk(rd, ctrl_word(8'h08, 8'h00, 16'h8283));
		chk(32'(rxr), 32'h1);
		apb(0, 12'h050, 0);
		chk(rd, 32'h3);
		for (int i = 0; i < 8; i++) begin
			apb(0, 12'h040, 0);
			chk(rd, q[i]);
		end
		apb(0, 12'h030, 0);
		chk(rd, ctrl_word(8'h00, 8'h00, 16'h8283));
		chk(32'(rxr), 32'h0);
		apb(1, 12'h054, 0);
		chk(32'(irq), 32'h0);
		apb(1, 12'h030, 32'h0000_0203);
		chk(32'(txr), 32'h0);
		apb(0, 12'h060, 0);
		chk(rd, 32'h0);
		chk(32'(e), 32'h1);
		end_sim();
	end
endmodule : testbench
